// ---- logic/wdf_pkg.sv ----
// Constants and types shared by the FUA extended DMA write engine
package wdf_pkg;
    //****************************************
    // Command code
    //****************************************
    localparam logic [7:0] CMD_WR_FUA_EXT = 8'h3d;

    //****************************************
    // APB register byte offsets
    //****************************************
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_DATA = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_ERR = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_SCNT = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_SNUM = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_CYLO = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_CYHI = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_DEVH = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_STAT = 12'h01c;
    localparam logic [ADDR_W-1:0] OFS_DCTL = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_ISTA = 12'h024;
    localparam logic [ADDR_W-1:0] OFS_IMSK = 12'h028;

    //****************************************
    // Field positions and values
    //****************************************
    localparam int ERR_CRC = 7;
    localparam int ERR_IDN = 4;
    localparam int ERR_ABT = 2;
    localparam logic [7:0] ERR_MASK = 8'h94;
    localparam int ST_RDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_ERR = 0;
    localparam logic [7:0] RST_STATUS = 8'h50;
    localparam logic [7:0] ERR_STATUS = 8'h51;
    localparam int DCTL_HOB = 7;
    localparam int INT_N = 2;
    localparam int INT_DONE = 0;
    localparam int INT_DROP = 1;

    //****************************************
    // Transfer sizes
    //****************************************
    localparam int WORDS_PER_SECTOR = 256;
    localparam logic [16:0] SEC_CNT_ZERO = 17'h10000;

    typedef enum logic [1:0] {
        WDF_IDLE = 2'b00,
        WDF_XFER = 2'b01,
        WDF_COMMIT = 2'b10
    } wdf_state_t;
endpackage : wdf_pkg

// ---- logic/wdf_irq_if.sv ----
// Event and mask signals between the engine and its interrupt unit
`timescale 1ns/1ps
`default_nettype none
interface wdf_irq_if #(
    parameter int N = wdf_pkg::INT_N
);
    logic [N-1:0] ev;
    logic [N-1:0] clr;
    logic [N-1:0] maskIn;
    logic maskWr;
    logic [N-1:0] stat;
    logic [N-1:0] mask;
    logic irq;
    modport core (output ev, clr, maskIn, maskWr, input stat, mask, irq);
    modport unit (input ev, clr, maskIn, maskWr, output stat, mask, irq);
endinterface : wdf_irq_if
`default_nettype wire

// ---- logic/wdf_irq.sv ----
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ps
`default_nettype none
module wdf_irq (
    // Clock and synchronised reset
    input wire logic mclk,
    input wire logic rstN,
    // Engine side
    wdf_irq_if.unit ir
);
    import wdf_pkg::*;

    typedef struct packed {
        logic [INT_N-1:0] stat;
        logic [INT_N-1:0] mask;
        logic irq;
    } wdf_irq_state_t;

    wdf_irq_state_t s;
    wdf_irq_state_t n;

    //****************************************
    // Next state
    //****************************************
    always_comb
    begin
        n = s;
        // Set beats clear so no event is lost
        n.stat = (s.stat & ~ir.clr) | ir.ev;
        if (ir.maskWr)
        begin
            n.mask = ir.maskIn;
        end
        n.irq = |(n.stat & n.mask);
    end

    always_ff @(posedge mclk or negedge rstN)
    begin
        if (!rstN)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign ir.stat = s.stat;
    assign ir.mask = s.mask;
    assign ir.irq = s.irq;

    a_set_wins: assert property (@(posedge mclk) disable iff (!rstN)
        ir.ev[INT_DONE] |=> s.stat[INT_DONE])
        else $error("done event lost");
endmodule : wdf_irq
`default_nettype wire

// ---- logic/wdf_top.sv ----
// FUA extended DMA write command engine behind an APB taskfile
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
//****************************************
// What this block does
// - Code 3Dh starts FUA extended write
// - All sectors committed before ending status
// - Data arrives as 16-bit words
// - Data words accepted only under dmaReq
// - One interrupt per command, after status
// - Unrecoverable error stops at failing sector
// - Sixteen-bit count, zero means 65536
// - Failing LBA reported in address registers
// - Error register shows only CRC, IDN, ABT
// - Ending status clears BSY, DF, COR
//****************************************
module wdf_top #(
    parameter int WORDS_PER_SECTOR = wdf_pkg::WORDS_PER_SECTOR
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // APB slave
    input wire logic [wdf_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host DMA request
    output logic dmaReq,
    // Media write port
    output logic mediaValid,
    output logic [15:0] mediaWord,
    output logic mediaLast,
    input wire logic mediaReady,
    input wire logic mediaSecAck,
    input wire logic mediaFault,
    input wire logic linkCrcFault,
    // Interrupt
    output logic irq
);
    import wdf_pkg::*;

    localparam int WIDX_W = $clog2(WORDS_PER_SECTOR);
    localparam logic [WIDX_W-1:0] LAST_WORD =
        WIDX_W'(WORDS_PER_SECTOR - 1);

    typedef struct packed {
        wdf_state_t state;
        logic [15:0] cnt;
        logic [15:0] snum;
        logic [15:0] cylo;
        logic [15:0] cyhi;
        logic [7:0] devh;
        logic hob;
        logic [7:0] errBits;
        logic [7:0] status;
        logic [WIDX_W-1:0] wordIdx;
        logic [16:0] xferLeft;
        logic [16:0] ackLeft;
        logic [47:0] ackLba;
        logic dmaReq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic mediaValid;
        logic mediaLast;
        logic [15:0] mediaWord;
        logic doneEv;
        logic dropEv;
    } wdf_core_t;

    wdf_core_t s;
    wdf_core_t n;

    //****************************************
    // Reset release
    //****************************************
    logic rstMeta;
    logic rstN;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    //****************************************
    // Interrupt unit
    //****************************************
    wdf_irq_if #(.N(INT_N)) irBus();

    wdf_irq uIrq (
        .mclk(mclk),
        .rstN(rstN),
        .ir(irBus.unit)
    );

    assign irBus.ev = {s.dropEv, s.doneEv};

    function automatic logic [31:0] hobSel(input logic [15:0] r,
                                           input logic h);
        hobSel = {24'h0, h ? r[15:8] : r[7:0]};
    endfunction : hobSel

    //****************************************
    // Next state
    //****************************************
    logic busy;
    logic acc;
    logic fin;
    logic mapped;
    logic stall;
    logic fault;
    logic [31:0] rdVal;
    logic [47:0] startLba;
    logic [47:0] failLba;

    always_comb
    begin
        n = s;
        n.mediaValid = 1'b0;
        n.mediaLast = 1'b0;
        n.doneEv = 1'b0;
        n.dropEv = 1'b0;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.prdata = 32'h0;
        busy = s.state != WDF_IDLE;
        acc = psel && penable;
        fin = acc && s.pready;
        fault = busy && (mediaFault || linkCrcFault);
        startLba = {s.cyhi[15:8], s.cylo[15:8], s.snum[15:8],
                    s.cyhi[7:0], s.cylo[7:0], s.snum[7:0]};
        // A sector acked with the fault was good; blame the next
        failLba = mediaSecAck ? s.ackLba + 48'h1 : s.ackLba;
        mapped = 1'b1;
        case (paddr)
            OFS_DATA: rdVal = 32'h0;
            OFS_ERR: rdVal = {24'h0, s.errBits & ERR_MASK};
            OFS_SCNT: rdVal = hobSel(s.cnt, s.hob);
            OFS_SNUM: rdVal = hobSel(s.snum, s.hob);
            OFS_CYLO: rdVal = hobSel(s.cylo, s.hob);
            OFS_CYHI: rdVal = hobSel(s.cyhi, s.hob);
            OFS_DEVH: rdVal = {24'h0, s.devh};
            OFS_STAT: rdVal = {24'h0, busy, s.status[ST_RDY], 1'b0,
                               s.status[ST_DSC], s.dmaReq, 2'b00,
                               s.status[ST_ERR]};
            OFS_DCTL: rdVal = {24'h0, s.hob, 7'h0};
            OFS_ISTA: rdVal = 32'(irBus.stat);
            OFS_IMSK: rdVal = 32'(irBus.mask);
            default:
            begin
                rdVal = 32'h0;
                mapped = 1'b0;
            end
        endcase

        // Media back-pressure holds the data write in wait states
        stall = pwrite && paddr == OFS_DATA && s.dmaReq && !mediaReady;
        if (acc && !s.pready && !stall)
        begin
            n.pready = 1'b1;
            n.pslverr = !mapped;
            n.prdata = (pwrite || !mapped) ? 32'h0 : rdVal;
        end

        irBus.clr = (fin && pwrite && paddr == OFS_ISTA) ?
            pwdata[INT_N-1:0] : '0;
        irBus.maskWr = fin && pwrite && paddr == OFS_IMSK;
        irBus.maskIn = pwdata[INT_N-1:0];

        // Count and LBA loads shift current byte into previous; DEVH loads whole
        if (fin && pwrite && paddr == OFS_DCTL)
        begin
            n.hob = pwdata[DCTL_HOB];
        end
        if (fin && pwrite && !busy)
        begin
            case (paddr)
                OFS_SCNT: n.cnt = {s.cnt[7:0], pwdata[7:0]};
                OFS_SNUM: n.snum = {s.snum[7:0], pwdata[7:0]};
                OFS_CYLO: n.cylo = {s.cylo[7:0], pwdata[7:0]};
                OFS_CYHI: n.cyhi = {s.cyhi[7:0], pwdata[7:0]};
                OFS_DEVH: n.devh = pwdata[7:0];
                OFS_STAT:
                begin
                    if (pwdata[7:0] == CMD_WR_FUA_EXT)
                    begin
                        n.state = WDF_XFER;
                        n.dmaReq = 1'b1;
                        n.xferLeft = (s.cnt == 16'h0) ? SEC_CNT_ZERO :
                            {1'b0, s.cnt};
                        n.ackLeft = n.xferLeft;
                        n.ackLba = startLba;
                        n.wordIdx = '0;
                        n.errBits = 8'h0;
                        n.status = RST_STATUS;
                    end
                    else
                    begin
                        // Only this command is served; others abort
                        n.errBits = 8'h0;
                        n.errBits[ERR_ABT] = 1'b1;
                        n.status = ERR_STATUS;
                        n.doneEv = 1'b1;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Data words go straight to the media port
        if (fin && pwrite && paddr == OFS_DATA)
        begin
            if (s.dmaReq)
            begin
                n.mediaValid = 1'b1;
                n.mediaWord = pwdata[15:0];
                n.wordIdx = s.wordIdx + 1'b1;
                if (s.wordIdx == LAST_WORD)
                begin
                    n.mediaLast = 1'b1;
                    n.wordIdx = '0;
                    n.xferLeft = s.xferLeft - 17'h1;
                    if (s.xferLeft == 17'h1)
                    begin
                        n.dmaReq = 1'b0;
                        n.state = WDF_COMMIT;
                    end
                end
            end
            else
            begin
                n.dropEv = 1'b1;
            end
        end

        // Ending status waits for every sector on the media
        if (busy && mediaSecAck)
        begin
            n.ackLba = s.ackLba + 48'h1;
            n.ackLeft = s.ackLeft - 17'h1;
            if (s.state == WDF_COMMIT && s.ackLeft == 17'h1)
            begin
                n.state = WDF_IDLE;
                n.status = RST_STATUS;
                n.errBits = 8'h0;
                n.doneEv = 1'b1;
            end
        end

        // Unrecoverable fault ends the command at once
        if (fault)
        begin
            n.state = WDF_IDLE;
            n.dmaReq = 1'b0;
            n.errBits = 8'h0;
            n.errBits[ERR_CRC] = linkCrcFault;
            n.errBits[ERR_ABT] = linkCrcFault;
            n.errBits[ERR_IDN] = mediaFault;
            n.ackLba = failLba;
            n.snum = {failLba[31:24], failLba[7:0]};
            n.cylo = {failLba[39:32], failLba[15:8]};
            n.cyhi = {failLba[47:40], failLba[23:16]};
            n.status = ERR_STATUS;
            n.doneEv = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstN)
    begin
        if (!rstN)
        begin
            s <= '0;
            s.status <= RST_STATUS;
        end
        else
        begin
            s <= n;
        end
    end

    //****************************************
    // Outputs
    //****************************************
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign dmaReq = s.dmaReq;
    assign mediaValid = s.mediaValid;
    assign mediaWord = s.mediaWord;
    assign mediaLast = s.mediaLast;
    assign irq = irBus.irq;

    //****************************************
    // Assertions
    //****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstN);

    sequence startCmd;
        fin && pwrite && paddr == OFS_STAT && !busy &&
            pwdata[7:0] == CMD_WR_FUA_EXT;
    endsequence

    sequence dataWr;
        fin && pwrite && paddr == OFS_DATA;
    endsequence

    sequence lastAck;
        s.state == WDF_COMMIT && mediaSecAck && s.ackLeft == 17'h1 &&
            !mediaFault && !linkCrcFault;
    endsequence

    a_start_xfer: assert property (startCmd |=>
        s.state == WDF_XFER && dmaReq && !s.doneEv)
        else $error("command 3d did not start a transfer");

    a_word_out: assert property (dataWr ##0 s.dmaReq |=>
        mediaValid && mediaWord == $past(pwdata[15:0]))
        else $error("data word not forwarded");

    a_word_drop: assert property (dataWr ##0 !s.dmaReq |=>
        !mediaValid ##1 irBus.stat[INT_DROP])
        else $error("word taken without request");

    a_commit_end: assert property (lastAck |=>
        s.state == WDF_IDLE && s.doneEv && s.status == RST_STATUS)
        else $error("ending status not posted");

    a_commit_hold: assert property (s.state == WDF_COMMIT &&
        !mediaSecAck && !mediaFault && !linkCrcFault |=>
        s.state == WDF_COMMIT && !s.doneEv)
        else $error("status before media commit");

    a_one_irq: assert property (s.doneEv |->
        s.state == WDF_IDLE && !dmaReq ##1 !s.doneEv)
        else $error("second interrupt event");

    a_fault_stop: assert property (busy && mediaFault |=>
        !dmaReq && s.state == WDF_IDLE && s.errBits[ERR_IDN])
        else $error("write continued after fault");

    a_zero_count: assert property (startCmd ##0 s.cnt == 16'h0 |=>
        s.xferLeft == SEC_CNT_ZERO)
        else $error("zero count not 65536");

    a_fail_lba: assert property (busy && mediaFault && !mediaSecAck
        |=> {s.cyhi[15:8], s.cylo[15:8], s.snum[15:8], s.cyhi[7:0],
         s.cylo[7:0], s.snum[7:0]} == $past(s.ackLba))
        else $error("failing LBA wrong");

    a_err_bits: assert property (acc && !s.pready && !pwrite &&
        paddr == OFS_ERR |=> (prdata & 32'h0000006b) == 32'h0)
        else $error("reserved error bits set");

    a_end_status: assert property ($fell(busy) |->
        s.status[ST_RDY] && s.status[ST_DSC] && !dmaReq)
        else $error("bad ending status");

    a_start_lba: assert property (startCmd |=>
        s.ackLba == {$past(s.cyhi[15:8]), $past(s.cylo[15:8]),
                     $past(s.snum[15:8]), $past(s.cyhi[7:0]),
                     $past(s.cylo[7:0]), $past(s.snum[7:0])})
        else $error("start LBA wrong");
endmodule : wdf_top
`default_nettype wire

// ---- sim/wdf_media_model.sv ----
// Media partner: takes words, commits whole sectors in order
`timescale 1ns/1ps
`default_nettype none
module wdf_media_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Word port
    input wire logic mediaValid,
    input wire logic [15:0] mediaWord,
    input wire logic mediaLast,
    output logic mediaReady,
    output logic mediaSecAck,
    output logic mediaFault,
    // Bench controls
    input wire logic slow,
    input wire logic [7:0] failSec,
    output logic [15:0] lastWord,
    output logic [15:0] wordCnt
);
    logic [7:0] rcv;
    logic [7:0] ack;
    logic [3:0] tmr;
    logic [1:0] stall;
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            {rcv, ack, tmr, stall, wordCnt, lastWord} <= '0;
            {mediaReady, mediaSecAck, mediaFault} <= '0;
        end
        else
        begin
            mediaSecAck <= 1'b0;
            mediaFault <= 1'b0;
            // Ready stays up until a word lands
            if (mediaValid)
            begin
                mediaReady <= 1'b0;
                stall <= slow ? 2'h3 : 2'h0;
                lastWord <= mediaWord;
                wordCnt <= wordCnt + 16'h1;
                if (mediaLast)
                    rcv <= rcv + 8'h1;
            end
            else if (stall != 2'h0)
                stall <= stall - 2'h1;
            else
                mediaReady <= 1'b1;
            // Slow commit, so status must wait for it
            if (rcv == ack)
                tmr <= '0;
            else if (tmr != 4'hf)
                tmr <= tmr + 4'h1;
            else
            begin
                tmr <= '0;
                if (ack == failSec)
                begin
                    mediaFault <= 1'b1;
                    ack <= rcv;
                end
                else
                begin
                    mediaSecAck <= 1'b1;
                    ack <= ack + 8'h1;
                end
            end
        end
    end
endmodule : wdf_media_model
`default_nettype wire

// ---- sim/wdf_top_tb.sv ----
// Self-checking bench for the FUA extended write engine
`timescale 1ns/1ps
`default_nettype none
module wdf_top_tb;
    import wdf_pkg::*;
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr, dmaReq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic mediaValid, mediaLast, mediaReady, mediaSecAck, mediaFault;
    logic linkCrcFault, irq, slow, err;
    logic [15:0] mediaWord, lastWord, wordCnt;
    logic [7:0] failSec;
    int errors, compares;
    logic [7:0] bad [2] = '{8'h35, 8'hca};
    wdf_top #(.WORDS_PER_SECTOR(4)) i_dut (.mclk(mclk), .nrst(nrst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dmaReq(dmaReq), .mediaValid(mediaValid),
        .mediaWord(mediaWord), .mediaLast(mediaLast),
        .mediaReady(mediaReady), .mediaSecAck(mediaSecAck),
        .mediaFault(mediaFault), .linkCrcFault(linkCrcFault), .irq(irq));
    wdf_media_model i_media (.mclk(mclk), .nrst(nrst),
        .mediaValid(mediaValid), .mediaWord(mediaWord),
        .mediaLast(mediaLast), .mediaReady(mediaReady),
        .mediaSecAck(mediaSecAck), .mediaFault(mediaFault), .slow(slow),
        .failSec(failSec), .lastWord(lastWord), .wordCnt(wordCnt));
    always #50 mclk = ~mclk;
    //****************************************
    // Tasks
    //****************************************
    task automatic stop_test();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic guard(input int n);
        if (n >= 200)
        begin
            errors++;
            stop_test();
        end
    endtask : guard
    // Request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [15:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 200);
        guard(n);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so registered effects have settled on return
        @(posedge mclk);
    endtask : apb
    task automatic wr8(input logic [11:0] a, input logic [7:0] b);
        apb(1'b1, a, {8'h0, b});
    endtask : wr8
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 16'h0);
        chk(rd, {24'h0, e});
    endtask : rdc
    task automatic start(input logic [15:0] c, input logic [47:0] l,
                         input logic [7:0] cmd);
        wr8(OFS_SCNT, c[15:8]);
        wr8(OFS_SCNT, c[7:0]);
        wr8(OFS_SNUM, l[31:24]);
        wr8(OFS_SNUM, l[7:0]);
        wr8(OFS_CYLO, l[39:32]);
        wr8(OFS_CYLO, l[15:8]);
        wr8(OFS_CYHI, l[47:40]);
        wr8(OFS_CYHI, l[23:16]);
        wr8(OFS_DEVH, 8'h40);
        // No separate channel here, so it is ready before this
        wr8(OFS_STAT, cmd);
    endtask : start
    task automatic words(input int n, input logic [15:0] b);
        for (int i = 0; i < n; i++)
            apb(1'b1, OFS_DATA, b + 16'(i));
    endtask : words
    task automatic waitIdle();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, OFS_STAT, 16'h0);
            n++;
        end
        while (rd[7] !== 1'b0 && n < 200);
        guard(n);
    endtask : waitIdle
    task automatic lbaChk(input logic [47:0] l);
        wr8(OFS_DCTL, 8'h00);
        rdc(OFS_SNUM, l[7:0]);
        rdc(OFS_CYLO, l[15:8]);
        rdc(OFS_CYHI, l[23:16]);
        wr8(OFS_DCTL, 8'h80);
        rdc(OFS_SNUM, l[31:24]);
        rdc(OFS_CYLO, l[39:32]);
        rdc(OFS_CYHI, l[47:40]);
        wr8(OFS_DCTL, 8'h00);
    endtask : lbaChk
    //****************************************
    // Tests
    //****************************************
    initial
    begin
        {mclk, nrst, psel, penable, pwrite, linkCrcFault, slow} = '0;
        paddr = '0;
        pwdata = '0;
        failSec = 8'hff;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        rdc(OFS_STAT, 8'h50);
        apb(1'b0, 12'h100, 16'h0);
        chk(32'(err), 32'h1);
        chk(32'(dmaReq), 32'h0);
        wr8(OFS_IMSK, 8'h01);
        $display("reset test done");
        slow <= 1'b1;
        start(16'h0002, 48'h0000_1234_5678, CMD_WR_FUA_EXT);
        chk(32'(dmaReq), 32'h1);
        words(8, 16'ha000);
        // Media counts the last word one edge after it is forwarded
        @(posedge mclk);
        chk(32'(wordCnt), 32'h8);
        chk(32'(lastWord), 32'ha007);
        // Data all in but media not done: still busy
        apb(1'b0, OFS_STAT, 16'h0);
        chk(32'(rd[7]), 32'h1);
        chk(32'({dmaReq, irq}), 32'h0);
        waitIdle();
        rdc(OFS_STAT, 8'h50);
        rdc(OFS_ERR, 8'h00);
        chk(32'(irq), 32'h1);
        rdc(OFS_ISTA, 8'h01);
        wr8(OFS_ISTA, 8'h01);
        rdc(OFS_ISTA, 8'h00);
        chk(32'(irq), 32'h0);
        apb(1'b1, OFS_DATA, 16'h5555);
        chk(32'(wordCnt), 32'h8);
        rdc(OFS_ISTA, 8'h02);
        wr8(OFS_ISTA, 8'h02);
        $display("commit test done");
        failSec <= 8'h3;
        start(16'h0003, 48'hab12_3456_789a, CMD_WR_FUA_EXT);
        words(8, 16'hb000);
        waitIdle();
        rdc(OFS_ERR, 8'h10);
        rdc(OFS_STAT, 8'h51);
        lbaChk(48'hab12_3456_789b);
        chk(32'(dmaReq), 32'h0);
        apb(1'b1, OFS_DATA, 16'h1111);
        chk(32'(wordCnt), 32'h10);
        chk(32'(irq), 32'h1);
        wr8(OFS_ISTA, 8'h03);
        failSec <= 8'hff;
        $display("media fault test done");
        slow <= 1'b0;
        start(16'h0000, 48'h0000_0000_0010, CMD_WR_FUA_EXT);
        words(8, 16'hc000);
        chk(32'(dmaReq), 32'h1);
        @(posedge mclk);
        linkCrcFault <= 1'b1;
        @(posedge mclk);
        linkCrcFault <= 1'b0;
        waitIdle();
        rdc(OFS_ERR, 8'h84);
        rdc(OFS_STAT, 8'h51);
        wr8(OFS_ISTA, 8'h03);
        $display("crc test done");
        // Other codes abort without moving data
        for (int i = 0; i < 2; i++)
        begin
            start(16'h0001, 48'h0, bad[i]);
            waitIdle();
            rdc(OFS_ERR, 8'h04);
            rdc(OFS_STAT, 8'h51);
            chk(32'(dmaReq), 32'h0);
            wr8(OFS_ISTA, 8'h01);
        end
        $display("abort test done");
        stop_test();
    end
endmodule : wdf_top_tb
`default_nettype wire
